// File: uadsc_defs.vh
/*
 Constants for the accessory detect and switch controller: register
 offsets, field positions, reset values, accessory classes and the
 serial slave address. Assumes inclusion by the controller and its bench models.
*/
`ifndef UADSC_DEFS_VH
`define UADSC_DEFS_VH

`define UADSC_SLAVE_ADDR      7'h25

`define UADSC_REG_CONTROL     8'h02
`define UADSC_REG_EVENTS      8'h03
`define UADSC_REG_ID_CODE     8'h07
`define UADSC_REG_USB_TYPE    8'h0a
`define UADSC_REG_FIX_TYPE    8'h0b
`define UADSC_REG_MANUAL      8'h13
`define UADSC_REG_RESET       8'h1b

`define UADSC_CTRL_RESET      8'h05
`define UADSC_SYNC_IDLE       9'h07f
`define UADSC_CTRL_MASK_BIT   0
`define UADSC_CTRL_AUTO_BIT   2

`define UADSC_EV_ATTACH_BIT   0
`define UADSC_EV_DETACH_BIT   1

`define UADSC_T1_SDP_BIT      2
`define UADSC_T1_WA_BIT       4
`define UADSC_T1_CDP_BIT      5
`define UADSC_T1_DCP_BIT      6

`define UADSC_T2_USB_OFF_BIT  0
`define UADSC_T2_USB_ON_BIT   1
`define UADSC_T2_UART_OFF_BIT 2
`define UADSC_T2_UART_ON_BIT  3
`define UADSC_T2_UNKNOWN_BIT  7

`define UADSC_ROUTE_OPEN      2'h0
`define UADSC_ROUTE_PRIMARY   2'h1
`define UADSC_ROUTE_SECONDARY 2'h2

`define UADSC_ID_WA           5'h17
`define UADSC_ID_USB_OFF      5'h18
`define UADSC_ID_USB_ON       5'h19
`define UADSC_ID_UART_OFF     5'h1c
`define UADSC_ID_UART_ON      5'h1d
`define UADSC_ID_OPEN         5'h1f

`define UADSC_CL_NONE         4'h0
`define UADSC_CL_SDP          4'h1
`define UADSC_CL_CDP          4'h2
`define UADSC_CL_DCP          4'h3
`define UADSC_CL_WA           4'h4
`define UADSC_CL_USB_OFF      4'h5
`define UADSC_CL_USB_ON       4'h6
`define UADSC_CL_UART_OFF     4'h7
`define UADSC_CL_UART_ON      4'h8
`define UADSC_CL_UNKNOWN      4'h9

`endif

// File: uadsc_ctrl.v
/*
 Accessory detect and 2:1 data switch controller with its serial
 register slave. Assumes id code, bus power and data line sense come
 from analog blocks outside the clock domain; the serial master runs
 well below the 20 MHz system clock.
*/
`timescale 1ns/1ps
`include "uadsc_defs.vh"

module uadsc_ctrl #(
	parameter FIXTURE_ACTIVE_HIGH = 1'b0
) (
	input  wire       sys_clk,
	input  wire       reset_n,
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	input  wire [4:0] id_sense_pin,
	input  wire       vbus_valid,
	input  wire       conn_lines_shorted,
	input  wire       conn_cdp_seen,
	output wire       irq_n_out,
	output wire       primary_sw_on,
	output wire       secondary_sw_on,
	output wire       start_up_req,
	output wire       fixture_ind
);

	localparam ST_IDLE  = 3'h0;
	localparam ST_DEV   = 3'h1;
	localparam ST_REG   = 3'h2;
	localparam ST_WDATA = 3'h3;
	localparam ST_RDATA = 3'h4;
	localparam ST_RACK  = 3'h5;

	// Two-stage synchronisers
	reg  [8:0] sync1_ff;
	reg  [8:0] sync2_ff;
	reg        sync1_cdp_ff;
	reg        sync1_cdp2_ff;
	reg        scl_d_ff;
	reg        sda_d_ff;
	wire       scl_s  = sync2_ff[0];
	wire       sda_s  = sync2_ff[1];
	wire [4:0] id_s   = sync2_ff[6:2];
	wire       vbus_s = sync2_ff[7];

	// Serial slave state
	reg  [2:0] st_ff;
	reg  [3:0] cnt_ff;
	reg  [7:0] sh_ff;
	reg  [7:0] ptr_ff;
	reg        ack_ff;
	reg        match_ff;
	reg        rw_ff;
	reg        mack_ff;
	reg        sda_oe_ff;
	reg        sda_out_ff;

	// Register file and detection state
	reg  [7:0] ctrl_ff;
	reg  [7:0] ev_ff;
	reg  [7:0] type1_ff;
	reg  [7:0] type2_ff;
	reg  [7:0] man_ff;
	reg  [4:0] code_ff;
	reg  [3:0] cls_ff;
	reg        srst_ff;
	reg        irq_n_ff;
	reg        pri_ff;
	reg        sec_ff;
	reg        boot_ff;
	reg        fix_ff;

	wire scl_rise = scl_s & ~scl_d_ff;
	wire scl_fall = ~scl_s & scl_d_ff;
	wire start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

	function [3:0] classify;
		input [4:0] id;
		input       vb;
		input       shorted;
		input       cdp;
		begin
			case (id)
				`UADSC_ID_WA:       classify = vb ? `UADSC_CL_WA : `UADSC_CL_NONE;
				`UADSC_ID_USB_OFF:  classify = `UADSC_CL_USB_OFF;
				`UADSC_ID_USB_ON:   classify = `UADSC_CL_USB_ON;
				`UADSC_ID_UART_OFF: classify = `UADSC_CL_UART_OFF;
				`UADSC_ID_UART_ON:  classify = `UADSC_CL_UART_ON;
				`UADSC_ID_OPEN: begin
					if (!vb)
						classify = `UADSC_CL_NONE;
					else if (shorted)
						classify = `UADSC_CL_DCP;
					else if (cdp)
						classify = `UADSC_CL_CDP;
					else
						classify = `UADSC_CL_SDP;
				end
				default:            classify = `UADSC_CL_UNKNOWN;
			endcase
		end
	endfunction

	function [7:0] reg_read;
		input [7:0] a;
		begin
			case (a)
				`UADSC_REG_CONTROL:  reg_read = ctrl_ff;
				`UADSC_REG_EVENTS:   reg_read = ev_ff;
				`UADSC_REG_ID_CODE:  reg_read = {3'h0, code_ff};
				`UADSC_REG_USB_TYPE: reg_read = type1_ff;
				`UADSC_REG_FIX_TYPE: reg_read = type2_ff;
				`UADSC_REG_MANUAL:   reg_read = man_ff;
				default:             reg_read = 8'h00;
			endcase
		end
	endfunction

	// Classification and route decisions
	wire [3:0] nxt_cls = classify(id_s, vbus_s, sync2_ff[8], sync1_cdp2_ff);
	wire       is_fix  = (nxt_cls >= `UADSC_CL_USB_OFF) && (nxt_cls <= `UADSC_CL_UART_ON);
	wire       is_on   = (nxt_cls == `UADSC_CL_USB_ON) || (nxt_cls == `UADSC_CL_UART_ON);
	wire       det_ev  = (nxt_cls != cls_ff) ||
	                     ((nxt_cls == `UADSC_CL_UNKNOWN) && (id_s != code_ff));

	reg  [1:0] auto_route;
	reg  [7:0] nxt_type1;
	reg  [7:0] nxt_type2;
	always @* begin
		auto_route = `UADSC_ROUTE_OPEN;
		nxt_type1  = 8'h00;
		nxt_type2  = 8'h00;
		case (nxt_cls)
			`UADSC_CL_SDP: begin
				auto_route = `UADSC_ROUTE_PRIMARY;
				nxt_type1[`UADSC_T1_SDP_BIT] = 1'b1;
			end
			`UADSC_CL_CDP: begin
				auto_route = `UADSC_ROUTE_PRIMARY;
				nxt_type1[`UADSC_T1_CDP_BIT] = 1'b1;
			end
			`UADSC_CL_DCP: nxt_type1[`UADSC_T1_DCP_BIT] = 1'b1;
			`UADSC_CL_WA:  nxt_type1[`UADSC_T1_WA_BIT] = 1'b1;
			`UADSC_CL_USB_OFF: begin
				auto_route = `UADSC_ROUTE_PRIMARY;
				nxt_type2[`UADSC_T2_USB_OFF_BIT] = 1'b1;
			end
			`UADSC_CL_USB_ON: begin
				auto_route = `UADSC_ROUTE_PRIMARY;
				nxt_type2[`UADSC_T2_USB_ON_BIT] = 1'b1;
			end
			`UADSC_CL_UART_OFF: begin
				auto_route = `UADSC_ROUTE_SECONDARY;
				nxt_type2[`UADSC_T2_UART_OFF_BIT] = 1'b1;
			end
			`UADSC_CL_UART_ON: begin
				auto_route = `UADSC_ROUTE_SECONDARY;
				nxt_type2[`UADSC_T2_UART_ON_BIT] = 1'b1;
			end
			`UADSC_CL_UNKNOWN: nxt_type2[`UADSC_T2_UNKNOWN_BIT] = 1'b1;
			default: auto_route = `UADSC_ROUTE_OPEN;
		endcase
	end

	wire       auto_mode = ctrl_ff[`UADSC_CTRL_AUTO_BIT];
	wire [1:0] route     = auto_mode ? auto_route : man_ff[1:0];

	// Register accesses from the serial slave
	wire byte_done = scl_fall && (cnt_ff == 4'h8) && !ack_ff &&
	                 ((st_ff == ST_DEV) || (st_ff == ST_REG) || (st_ff == ST_WDATA));
	wire wr_en     = byte_done && (st_ff == ST_WDATA) && match_ff;
	wire rd_load   = scl_fall && ((ack_ff && match_ff && rw_ff && (st_ff == ST_DEV)) ||
	                 ((st_ff == ST_RACK) && mack_ff));
	wire [7:0] rd_addr = (st_ff == ST_RACK) ? ptr_ff + 8'h01 : ptr_ff;
	wire rd_clr    = rd_load && (rd_addr == `UADSC_REG_EVENTS);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_ff      <= `UADSC_SYNC_IDLE;
			sync2_ff      <= `UADSC_SYNC_IDLE;
			sync1_cdp_ff  <= 1'b0;
			sync1_cdp2_ff <= 1'b0;
			scl_d_ff      <= 1'b1;
			sda_d_ff      <= 1'b1;
		end else begin
			sync1_ff      <= {conn_lines_shorted, vbus_valid, id_sense_pin, sda_in, scl_in};
			sync2_ff      <= sync1_ff;
			sync1_cdp_ff  <= conn_cdp_seen;
			sync1_cdp2_ff <= sync1_cdp_ff;
			scl_d_ff      <= scl_s;
			sda_d_ff      <= sda_s;
		end
	end

	// Serial slave engine
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff      <= ST_IDLE;
			cnt_ff     <= 4'h0;
			sh_ff      <= 8'h00;
			ptr_ff     <= 8'h00;
			ack_ff     <= 1'b0;
			match_ff   <= 1'b0;
			rw_ff      <= 1'b0;
			mack_ff    <= 1'b0;
			sda_oe_ff  <= 1'b0;
			sda_out_ff <= 1'b0;
		end else if (stop_c) begin
			st_ff     <= ST_IDLE;
			sda_oe_ff <= 1'b0;
			ack_ff    <= 1'b0;
		end else if (start_c) begin
			st_ff     <= ST_DEV;
			cnt_ff    <= 4'h0;
			sda_oe_ff <= 1'b0;
			ack_ff    <= 1'b0;
			match_ff  <= 1'b0;
		end else begin
			if (scl_rise && !ack_ff &&
			    ((st_ff == ST_DEV) || (st_ff == ST_REG) || (st_ff == ST_WDATA))) begin
				sh_ff  <= {sh_ff[6:0], sda_s};
				cnt_ff <= cnt_ff + 4'h1;
			end
			if (scl_rise && (st_ff == ST_RACK))
				mack_ff <= ~sda_s;
			if (byte_done) begin
				cnt_ff <= 4'h0;
				if (st_ff == ST_DEV) begin
					match_ff  <= (sh_ff[7:1] == `UADSC_SLAVE_ADDR);
					rw_ff     <= sh_ff[0];
					ack_ff    <= 1'b1;
					sda_oe_ff <= (sh_ff[7:1] == `UADSC_SLAVE_ADDR);
				end else begin
					ack_ff    <= 1'b1;
					sda_oe_ff <= match_ff;
					if (st_ff == ST_REG)
						ptr_ff <= sh_ff;
					else
						ptr_ff <= ptr_ff + 8'h01;
				end
			end else if (rd_load) begin
				ack_ff    <= 1'b0;
				st_ff     <= ST_RDATA;
				ptr_ff    <= rd_addr;
				sh_ff     <= reg_read(rd_addr);
				sda_oe_ff <= ~|(reg_read(rd_addr) & 8'h80);
				cnt_ff    <= 4'h1;
			end else if (scl_fall && ack_ff) begin
				ack_ff    <= 1'b0;
				sda_oe_ff <= 1'b0;
				if (!match_ff)
					st_ff <= ST_IDLE;
				else if (st_ff == ST_DEV)
					st_ff <= ST_REG;
				else
					st_ff <= ST_WDATA;
			end else if (scl_fall && (st_ff == ST_RDATA)) begin
				if (cnt_ff == 4'h8) begin
					sda_oe_ff <= 1'b0;
					st_ff     <= ST_RACK;
				end else begin
					sda_oe_ff <= ~sh_ff[6];
					sh_ff     <= {sh_ff[6:0], 1'b0};
					cnt_ff    <= cnt_ff + 4'h1;
				end
			end else if (scl_fall && (st_ff == ST_RACK)) begin
				st_ff <= ST_IDLE;
			end
		end
	end

	// Registers, detection and outputs
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff  <= `UADSC_CTRL_RESET;
			ev_ff    <= 8'h00;
			type1_ff <= 8'h00;
			type2_ff <= 8'h00;
			man_ff   <= 8'h00;
			code_ff  <= `UADSC_ID_OPEN;
			cls_ff   <= `UADSC_CL_NONE;
			srst_ff  <= 1'b0;
			irq_n_ff <= 1'b1;
			pri_ff   <= 1'b0;
			sec_ff   <= 1'b0;
			boot_ff  <= 1'b0;
			fix_ff   <= ~FIXTURE_ACTIVE_HIGH;
		end else if (srst_ff) begin
			ctrl_ff  <= `UADSC_CTRL_RESET;
			ev_ff    <= 8'h00;
			type1_ff <= 8'h00;
			type2_ff <= 8'h00;
			man_ff   <= 8'h00;
			code_ff  <= `UADSC_ID_OPEN;
			cls_ff   <= `UADSC_CL_NONE;
			srst_ff  <= 1'b0;
			irq_n_ff <= 1'b1;
			pri_ff   <= 1'b0;
			sec_ff   <= 1'b0;
			boot_ff  <= 1'b0;
			fix_ff   <= ~FIXTURE_ACTIVE_HIGH;
		end else begin
			srst_ff <= wr_en && (ptr_ff == `UADSC_REG_RESET) && sh_ff[0];
			if (wr_en && (ptr_ff == `UADSC_REG_CONTROL))
				ctrl_ff <= sh_ff;
			if (wr_en && (ptr_ff == `UADSC_REG_MANUAL))
				man_ff <= sh_ff;
			cls_ff <= nxt_cls;
			if (det_ev) begin
				type1_ff <= nxt_type1;
				type2_ff <= nxt_type2;
				code_ff  <= id_s;
			end
			// Event flags: a new event wins over a read clear
			ev_ff[`UADSC_EV_ATTACH_BIT] <= (det_ev && (nxt_cls != `UADSC_CL_NONE)) ||
			                               (ev_ff[`UADSC_EV_ATTACH_BIT] && !rd_clr);
			ev_ff[`UADSC_EV_DETACH_BIT] <= (det_ev && (nxt_cls == `UADSC_CL_NONE)) ||
			                               (ev_ff[`UADSC_EV_DETACH_BIT] && !rd_clr);
			ev_ff[7:2] <= 6'h00;
			// Interrupt follows pending flags one cycle after they set, unless the control mask bit is set
			irq_n_ff <= ~((|ev_ff) && !ctrl_ff[`UADSC_CTRL_MASK_BIT]);
			pri_ff   <= (route == `UADSC_ROUTE_PRIMARY);
			sec_ff   <= (route == `UADSC_ROUTE_SECONDARY);
			boot_ff  <= is_fix && is_on;
			fix_ff   <= is_fix ? FIXTURE_ACTIVE_HIGH : ~FIXTURE_ACTIVE_HIGH;
		end
	end

	assign sda_out         = sda_out_ff;
	assign sda_oe          = sda_oe_ff;
	assign irq_n_out       = irq_n_ff;
	assign primary_sw_on   = pri_ff;
	assign secondary_sw_on = sec_ff;
	assign start_up_req    = boot_ff;
	assign fixture_ind     = fix_ff;

endmodule

// File: uadsc_ctrl_chk.sv
/* Pin checks for the accessory controller: fixture outputs, routes, interrupt hold.
 Assumes one clock domain and a bind placed at the foot of the bench top file. */
`timescale 1ns/1ps
module uadsc_ctrl_chk #(
	parameter FIXTURE_ACTIVE_HIGH = 1'b0
) (
	input wire       sys_clk,
	input wire       reset_n,
	input wire       scl_in,
	input wire [4:0] id_sense_pin,
	input wire       vbus_valid,
	input wire       conn_lines_shorted,
	input wire       irq_n_out,
	input wire       primary_sw_on,
	input wire       secondary_sw_on,
	input wire       start_up_req,
	input wire       fixture_ind
);
	wire usb_c  = id_sense_pin[4:1] == 4'hc;
	wire uart_c = id_sense_pin[4:1] == 4'he;
	wire fix_c  = usb_c | uart_c;
	wire dcp_c  = id_sense_pin == 5'h1f && vbus_valid && conn_lines_shorted;
	wire act    = FIXTURE_ACTIVE_HIGH;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	startup_on_a: assert property ((fix_c && id_sense_pin[0]) [*5] |-> start_up_req)
		else $error("start-up request low on a start-up-on code");
	startup_off_a: assert property ((fix_c && !id_sense_pin[0]) [*5] |-> !start_up_req)
		else $error("start-up request high on a start-up-off code");
	fixture_on_a: assert property (fix_c [*5] |-> fixture_ind == act)
		else $error("fixture indicator inactive on a fixture code");
	fixture_off_a: assert property ((!fix_c) [*5] |-> fixture_ind != act && !start_up_req)
		else $error("fixture outputs active without a fixture code");
	usb_route_a: assert property (usb_c [*5] |-> primary_sw_on && !secondary_sw_on)
		else $error("usb fixture not on primary pair");
	uart_route_a: assert property (uart_c [*5] |-> secondary_sw_on && !primary_sw_on)
		else $error("uart fixture not on secondary pair");
	dcp_open_a: assert property (dcp_c [*5] |-> !primary_sw_on && !secondary_sw_on)
		else $error("host pair closed on a dedicated charger");
	irq_hold_a: assert property ((scl_in [*6] ##0 !irq_n_out) |=> !irq_n_out)
		else $error("interrupt released without a register read");
endmodule

// File: uadsc_i2c_mst.sv
/* Serial master model standing in for the baseband processor.
 Assumes the bench resolves the open-drain data line with a pull-up. */
`timescale 1ns/1ps
`include "uadsc_defs.vh"
module uadsc_i2c_mst (
	input  wire sys_clk,
	input  wire sda_line,
	output reg  scl,
	output reg  sda_pull
);
	integer i;
	reg     s;
	initial scl = 1'b1;
	initial sda_pull = 1'b0;
	task hp;
		repeat (6) @(negedge sys_clk);
	endtask
	task bit_io(input b, output o);
		sda_pull = ~b;
		hp;
		scl = 1'b1;
		hp;
		o = sda_line;
		scl = 1'b0;
	endtask
	task start;
		sda_pull = 1'b0;
		hp;
		scl = 1'b1;
		hp;
		sda_pull = 1'b1;
		hp;
		scl = 1'b0;
	endtask
	task stop;
		sda_pull = 1'b1;
		hp;
		scl = 1'b1;
		hp;
		sda_pull = 1'b0;
		hp;
	endtask
	task tx(input [7:0] d);
		for (i = 7; i >= 0; i = i - 1)
			bit_io(d[i], s);
		bit_io(1'b1, s);
	endtask
	task wr(input [7:0] r, input [7:0] d);
		start;
		tx({`UADSC_SLAVE_ADDR, 1'b0});
		tx(r);
		tx(d);
		stop;
	endtask
	task rd(input [7:0] r, output [7:0] d);
		start;
		tx({`UADSC_SLAVE_ADDR, 1'b0});
		tx(r);
		start;
		tx({`UADSC_SLAVE_ADDR, 1'b1});
		for (i = 0; i < 8; i = i + 1) begin
			bit_io(1'b1, s);
			d = {d[6:0], s};
		end
		bit_io(1'b1, s);
		stop;
	endtask
endmodule

// File: tb_top.sv
/* Bench for the accessory controller: attach table, manual route, software reset.
 Assumes the checker and the serial master model are compiled first. */
`timescale 1ns/1ps
module tb_top;
	reg         sys_clk = 1'b0;
	reg         reset_n = 1'b0;
	reg  [4:0]  id = 5'h1f;
	reg  [2:0]  pw = 3'h0;
	reg  [7:0]  lf = 8'h59;
	reg  [7:0]  rv;
	wire        scl, m_pull, sda_oe, sda_out, irq_n, pri, sec, su, fix;
	wire        sda = ~m_pull & (~sda_oe | sda_out);
	integer     error_cnt = 0;
	integer     n_checks = 0;
	integer     cyc = 0;
	reg  [7:0]  exp_q[$];
	reg  [7:0]  got_q[$];
	string      nm_q[$];
	reg  [4:0]  unk[0:5] = '{5'h15, 5'h16, 5'h1a, 5'h1b, 5'h1e, 5'h05};
	always #25 sys_clk = ~sys_clk;
	uadsc_ctrl dut (.sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .id_sense_pin(id), .vbus_valid(pw[2]),
		.conn_lines_shorted(pw[1]), .conn_cdp_seen(pw[0]), .irq_n_out(irq_n),
		.primary_sw_on(pri), .secondary_sw_on(sec), .start_up_req(su), .fixture_ind(fix));
	uadsc_i2c_mst mst (.sys_clk(sys_clk), .sda_line(sda), .scl(scl), .sda_pull(m_pull));
	initial forever begin
		wait (got_q.size() != 0);
		n_checks = n_checks + 1;
		if (got_q[0] !== exp_q[0]) begin
			error_cnt = error_cnt + 1;
			$display("mismatch %s expected %h seen %h", nm_q[0], exp_q[0], got_q[0]);
		end
		void'(got_q.pop_front());
		void'(exp_q.pop_front());
		void'(nm_q.pop_front());
	end
	task note(input string n, input [7:0] e, input [7:0] g);
		nm_q.push_back(n);
		exp_q.push_back(e);
		got_q.push_back(g);
	endtask
	task chk_rd(input [7:0] a, input [7:0] e);
		mst.rd(a, rv);
		note($sformatf("reg %h", a), e, rv);
	endtask
	task chk_pins(input [4:0] e);
		note("pins", {3'h0, e}, {3'h0, irq_n, pri, sec, su, fix});
	endtask
	task step(input [4:0] i, input [2:0] p, input [7:0] ev, t1, t2, input [4:0] pn);
		@(negedge sys_clk);
		id = i;
		pw = p;
		repeat (6) @(negedge sys_clk);
		if (pn == 5'h1f)
			note("irq", 8'h00, {7'h0, irq_n});
		else
			chk_pins(pn);
		chk_rd(8'h03, ev);
		chk_rd(8'h0a, t1);
		chk_rd(8'h0b, t2);
	endtask
	function [7:0] nx(input [7:0] v);
		nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task report_and_stop;
		#1;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			error_cnt = error_cnt + 1;
			report_and_stop;
		end
	end
	initial begin
		repeat (12) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk_rd(8'h02, 8'h05);
		chk_rd(8'h20, 8'h00);
		chk_pins(5'h11);
		$display("reset defaults done");
		step(5'h1d, 3'h0, 8'h01, 8'h00, 8'h08, 5'h16);
		mst.wr(8'h02, 8'h04);
		step(5'h1c, 3'h0, 8'h01, 8'h00, 8'h04, 5'h04);
		step(5'h18, 3'h0, 8'h01, 8'h00, 8'h01, 5'h08);
		step(5'h19, 3'h0, 8'h01, 8'h00, 8'h02, 5'h0a);
		step(5'h1d, 3'h4, 8'h01, 8'h00, 8'h08, 5'h06);
		foreach (unk[k]) begin
			step(unk[k], 3'h0, 8'h01, 8'h00, 8'h80, 5'h1f);
			chk_rd(8'h07, {3'h0, unk[k]});
		end
		$display("fixture and unknown codes done");
		step(5'h1f, 3'h0, 8'h02, 8'h00, 8'h00, 5'h01);
		step(5'h17, 3'h7, 8'h01, 8'h10, 8'h00, 5'h1f);
		step(5'h1f, 3'h6, 8'h01, 8'h40, 8'h00, 5'h01);
		step(5'h1f, 3'h5, 8'h01, 8'h20, 8'h00, 5'h09);
		step(5'h1f, 3'h4, 8'h01, 8'h04, 8'h00, 5'h09);
		step(5'h1f, 3'h0, 8'h02, 8'h00, 8'h00, 5'h01);
		step(5'h17, 3'h0, 8'h00, 8'h00, 8'h00, 5'h11);
		$display("charger and detach done");
		mst.wr(8'h02, 8'h00);
		mst.wr(8'h13, 8'h02);
		step(5'h1f, 3'h4, 8'h01, 8'h04, 8'h00, 5'h05);
		mst.wr(8'h13, 8'h01);
		chk_pins(5'h19);
		chk_rd(8'h13, 8'h01);
		repeat (3) begin
			lf = nx(lf);
			mst.wr(8'h0a, lf);
			mst.wr(8'h20, lf);
			chk_rd(8'h0a, 8'h04);
			chk_rd(8'h20, 8'h00);
		end
		$display("manual route done");
		step(5'h1f, 3'h0, 8'h02, 8'h00, 8'h00, 5'h1f);
		mst.wr(8'h1b, 8'h01);
		chk_pins(5'h11);
		chk_rd(8'h02, 8'h05);
		chk_rd(8'h13, 8'h00);
		$display("software reset done");
		report_and_stop;
	end
endmodule
bind uadsc_ctrl uadsc_ctrl_chk #(.FIXTURE_ACTIVE_HIGH(FIXTURE_ACTIVE_HIGH)) chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .scl_in(scl_in), .id_sense_pin(id_sense_pin),
	.vbus_valid(vbus_valid), .conn_lines_shorted(conn_lines_shorted), .irq_n_out(irq_n_out),
	.primary_sw_on(primary_sw_on), .secondary_sw_on(secondary_sw_on),
	.start_up_req(start_up_req), .fixture_ind(fixture_ind));
